// ### rtl/nac_pkg.sv
// Constants of the aiding and state packet codec.
// Assumes one 40 MHz clock and an APB master on the same clock.
package nac_pkg;
   // ****************************************
   // Packet identifiers and lengths
   // ****************************************
   localparam logic [7:0] ID_BODY_VEL = 8'h2F;
   localparam logic [7:0] ID_HEADING = 8'h30;
   localparam logic [7:0] ID_RUN_TIME = 8'h31;
   localparam logic [7:0] ID_ODO = 8'h33;
   localparam logic [7:0] ID_EXT_TIME = 8'h34;
   localparam logic [7:0] ID_DEPTH = 8'h35;
   localparam logic [7:0] ID_GEOID = 8'h36;
   localparam logic [7:0] ID_CORR = 8'h37;
   localparam logic [7:0] ID_WIND = 8'h39;
   localparam logic [7:0] LEN_VEL_SHORT = 8'h10;
   localparam logic [7:0] LEN_VEL_LONG = 8'h18;
   localparam logic [7:0] LEN_PAIR = 8'h08;
   localparam logic [7:0] LEN_ODO = 8'h14;
   localparam logic [7:0] LEN_GEOID = 8'h04;
   localparam logic [7:0] LEN_WIND = 8'h0C;
   // ****************************************
   // Word store layout, one word per field
   // ****************************************
   localparam logic [4:0] BASE_VEL = 5'h00;
   localparam logic [4:0] BASE_HEADING = 5'h06;
   localparam logic [4:0] BASE_RUN = 5'h08;
   localparam logic [4:0] BASE_ODO = 5'h0A;
   localparam logic [4:0] BASE_TIME = 5'h0F;
   localparam logic [4:0] BASE_DEPTH = 5'h11;
   localparam logic [4:0] BASE_GEOID = 5'h13;
   localparam logic [4:0] BASE_WIND = 5'h14;
   localparam logic [4:0] ODO_ACTIVE_WORD = 5'h0E;
   localparam int NWORDS = 23;
   localparam int STG_WORDS = 6;
   localparam logic [31:0] ODO_ACTIVE_MASK = 32'h0000_00FF;
   // ****************************************
   // APB map
   // ****************************************
   localparam logic [11:0] ADDR_STATUS = 12'h0080;
   localparam logic [11:0] ADDR_CTRL = 12'h0084;
   localparam int ST_WIND_FIXED = 0;
   localparam int ST_WIND_VALID = 1;
   localparam int ST_FRESH_LO = 8;
   localparam int ST_DISCARD = 13;
   localparam int CTRL_AIR = 0;
   localparam int CTRL_RESUME = 1;
endpackage : nac_pkg

// ### rtl/nac_codec.sv
// Aiding and state packet codec with APB access to the field store.
// Assumes a framer that delivers checked headers and payload bytes on ref_clk.
//
// Functional notes
// - Body velocity packet 47 accepted with 16 or 24 byte payload.
// - Velocities at 0,4,8, X deviation 12; Y,Z deviations only in long form.
// - Heading packet 48, eight bytes, heading and deviation, read and write.
// - Running time packet 49, read only: seconds then microseconds.
// - Odometer packet 51, read only, twenty bytes, active byte, three zero bytes.
// - External time packet 52 accepted only as an eight byte write.
// - Depth packet 53, eight bytes, depth and deviation, read and write.
// - Geoid height packet 54, read only, one four byte value.
// - Corrections packet 55 write only, up to 255 bytes, passed on unchanged.
// - Wind packet 57, twelve bytes, north, east, deviation, read and write.
// - A wind write stops wind estimation; written values then stay fixed.
// - Wind shown valid only while air data or a pitot input is present.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// ****************************************
// Two-entry buffer
// ****************************************
module nac_buf2 #(
   parameter int W = 9
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem [2];
   logic [1:0] count;
   logic rd_ptr;
   logic wr_ptr;
   logic push;
   logic pop;

   assign in_ready = (count != 2'd2);
   assign out_valid = (count != 2'd0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         count <= 2'd0;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
      end else begin
         count <= count + {1'b0, push} - {1'b0, pop};
         if (push) begin
            wr_ptr <= !wr_ptr;
         end
         if (pop) begin
            rd_ptr <= !rd_ptr;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : nac_buf2

// ****************************************
// Codec top
// ****************************************
module nac_codec (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hdr_valid,
   output logic hdr_ready,
   input wire logic [7:0] hdr_id,
   input wire logic [7:0] hdr_len,
   input wire logic hdr_write,
   input wire logic pl_valid,
   output logic pl_ready,
   input wire logic [7:0] pl_data,
   output logic corr_valid,
   input wire logic corr_ready,
   output logic [7:0] corr_data,
   output logic corr_last,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_last,
   output logic [7:0] tx_id,
   output logic [7:0] tx_len,
   input wire logic pitot_present,
   output logic wind_valid,
   output logic wind_fixed
);
   typedef enum logic [4:0] {
      NAC_IDLE = 5'b00001,
      NAC_RECV = 5'b00010,
      NAC_DROP = 5'b00100,
      NAC_CORR = 5'b01000,
      NAC_SEND = 5'b10000
   } nac_state_t;

   nac_state_t state;
   logic [31:0] wd [nac_pkg::NWORDS];
   logic [31:0] stg [nac_pkg::STG_WORDS];
   logic [31:0] next_stg [nac_pkg::STG_WORDS];
   logic [7:0] cur_id;
   logic [7:0] cur_len;
   logic [7:0] cnt;
   logic [4:0] cur_base;
   logic pl_last;
   logic commit;
   logic ctrl_air;
   logic [4:0] fresh;
   logic discard;
   logic pitot_s1;
   logic pitot_s2;
   logic buf_in_ready;
   logic [31:0] tx_word;
   logic [7:0] tx_byte;
   logic [8:0] buf_out;
   logic apb_wr;
   logic [4:0] widx;

   // ****************************************
   // Packet tables
   // ****************************************
   function automatic logic [4:0] pkt_base(input logic [7:0] id);
      case (id)
         nac_pkg::ID_HEADING: pkt_base = nac_pkg::BASE_HEADING;
         nac_pkg::ID_RUN_TIME: pkt_base = nac_pkg::BASE_RUN;
         nac_pkg::ID_ODO: pkt_base = nac_pkg::BASE_ODO;
         nac_pkg::ID_EXT_TIME: pkt_base = nac_pkg::BASE_TIME;
         nac_pkg::ID_DEPTH: pkt_base = nac_pkg::BASE_DEPTH;
         nac_pkg::ID_GEOID: pkt_base = nac_pkg::BASE_GEOID;
         nac_pkg::ID_WIND: pkt_base = nac_pkg::BASE_WIND;
         default: pkt_base = nac_pkg::BASE_VEL;
      endcase
   endfunction : pkt_base

   // Length accepted for a write; zero means the write is refused.
   function automatic logic wr_ok(input logic [7:0] id, input logic [7:0] len);
      case (id)
         nac_pkg::ID_BODY_VEL: wr_ok = (len == nac_pkg::LEN_VEL_SHORT) ||
                                      (len == nac_pkg::LEN_VEL_LONG);
         nac_pkg::ID_HEADING: wr_ok = (len == nac_pkg::LEN_PAIR);
         nac_pkg::ID_EXT_TIME: wr_ok = (len == nac_pkg::LEN_PAIR);
         nac_pkg::ID_DEPTH: wr_ok = (len == nac_pkg::LEN_PAIR);
         nac_pkg::ID_WIND: wr_ok = (len == nac_pkg::LEN_WIND);
         default: wr_ok = 1'b0;
      endcase
   endfunction : wr_ok

   // Length emitted on a read; zero means the identifier is not readable.
   function automatic logic [7:0] rd_len(input logic [7:0] id);
      case (id)
         nac_pkg::ID_BODY_VEL: rd_len = nac_pkg::LEN_VEL_LONG;
         nac_pkg::ID_HEADING: rd_len = nac_pkg::LEN_PAIR;
         nac_pkg::ID_RUN_TIME: rd_len = nac_pkg::LEN_PAIR;
         nac_pkg::ID_ODO: rd_len = nac_pkg::LEN_ODO;
         nac_pkg::ID_DEPTH: rd_len = nac_pkg::LEN_PAIR;
         nac_pkg::ID_GEOID: rd_len = nac_pkg::LEN_GEOID;
         nac_pkg::ID_WIND: rd_len = nac_pkg::LEN_WIND;
         default: rd_len = 8'h00;
      endcase
   endfunction : rd_len

   // ****************************************
   // Packet sequencing
   // ****************************************
   assign hdr_ready = (state == NAC_IDLE);
   assign pl_last = (cnt == cur_len - 8'd1);
   assign pl_ready = (state == NAC_RECV) || (state == NAC_DROP) ||
                     ((state == NAC_CORR) && corr_ready);
   assign commit = (state == NAC_RECV) && pl_valid && pl_last;
   assign corr_valid = (state == NAC_CORR) && pl_valid;
   assign corr_data = pl_data;
   assign corr_last = pl_last;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         state <= NAC_IDLE;
         cnt <= 8'h00;
         cur_id <= 8'h00;
         cur_len <= 8'h00;
         cur_base <= 5'h00;
      end else begin
         case (state)
            NAC_IDLE: begin
               cnt <= 8'h00;
               if (hdr_valid) begin
                  cur_id <= hdr_id;
                  cur_base <= pkt_base(hdr_id);
                  if (hdr_write) begin
                     cur_len <= hdr_len;
                     if (hdr_len == 8'h00) begin
                        state <= NAC_IDLE;
                     end else if (hdr_id == nac_pkg::ID_CORR) begin
                        state <= NAC_CORR;
                     end else if (wr_ok(hdr_id, hdr_len)) begin
                        state <= NAC_RECV;
                     end else begin
                        state <= NAC_DROP;
                     end
                  end else begin
                     cur_len <= rd_len(hdr_id);
                     if (rd_len(hdr_id) != 8'h00) begin
                        state <= NAC_SEND;
                     end
                  end
               end
            end
            NAC_RECV, NAC_DROP, NAC_CORR: begin
               if (pl_valid && pl_ready) begin
                  cnt <= cnt + 8'd1;
                  if (pl_last) begin
                     state <= NAC_IDLE;
                  end
               end
            end
            NAC_SEND: begin
               if (buf_in_ready) begin
                  cnt <= cnt + 8'd1;
                  if (pl_last) begin
                     state <= NAC_IDLE;
                  end
               end
            end
            default: state <= NAC_IDLE;
         endcase
      end
   end

   // Payload is staged whole, so a short or cut packet never touches the store.
   always_comb begin
      for (int i = 0; i < nac_pkg::STG_WORDS; i++) begin
         next_stg[i] = stg[i];
      end
      next_stg[cnt[4:2]][8*cnt[1:0] +: 8] = pl_data;
   end

   always_ff @(posedge ref_clk) begin
      if (state == NAC_RECV && pl_valid) begin
         stg[cnt[4:2]][8*cnt[1:0] +: 8] <= pl_data;
      end
   end

   // ****************************************
   // Field store
   // ****************************************
   assign apb_wr = psel && penable && pwrite;
   assign widx = paddr[6:2];

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < nac_pkg::NWORDS; i++) begin
            wd[i] <= 32'h0000_0000;
         end
      end else begin
         if (apb_wr && paddr[11:7] == 5'h00) begin
            if (widx == nac_pkg::ODO_ACTIVE_WORD) begin
               wd[widx] <= pwdata & nac_pkg::ODO_ACTIVE_MASK;
            end else if ((widx >= nac_pkg::BASE_RUN && widx < nac_pkg::BASE_TIME) ||
                         widx == nac_pkg::BASE_GEOID ||
                         (widx >= nac_pkg::BASE_WIND && widx < 5'(nac_pkg::NWORDS) && !wind_fixed)) begin
               wd[widx] <= pwdata;
            end
         end
         if (commit) begin
            for (int i = 0; i < nac_pkg::STG_WORDS; i++) begin
               if (i < int'(cur_len[7:2])) begin
                  wd[cur_base + 5'(i)] <= next_stg[i];
               end
            end
            if (cur_id == nac_pkg::ID_BODY_VEL && cur_len == nac_pkg::LEN_VEL_SHORT) begin
               wd[nac_pkg::BASE_VEL + 5'd4] <= next_stg[3];
               wd[nac_pkg::BASE_VEL + 5'd5] <= next_stg[3];
            end
         end
      end
   end

   // ****************************************
   // Wind control and status
   // ****************************************
   always_ff @(posedge ref_clk) begin
      pitot_s1 <= pitot_present;
      pitot_s2 <= pitot_s1;
   end

   assign wind_valid = ctrl_air || pitot_s2;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wind_fixed <= 1'b0;
      end else if (commit && cur_id == nac_pkg::ID_WIND) begin
         wind_fixed <= 1'b1;
      end else if (apb_wr && paddr == nac_pkg::ADDR_CTRL && pwdata[nac_pkg::CTRL_RESUME]) begin
         wind_fixed <= 1'b0;
      end
   end

   // A new packet setting a flag wins over a write-one clear in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         fresh <= 5'h00;
         discard <= 1'b0;
         ctrl_air <= 1'b0;
      end else begin
         if (apb_wr && paddr == nac_pkg::ADDR_CTRL) begin
            ctrl_air <= pwdata[nac_pkg::CTRL_AIR];
         end
         if (apb_wr && paddr == nac_pkg::ADDR_STATUS) begin
            fresh <= fresh & ~pwdata[nac_pkg::ST_FRESH_LO +: 5];
            discard <= discard & ~pwdata[nac_pkg::ST_DISCARD];
         end
         if (commit) begin
            case (cur_id)
               nac_pkg::ID_BODY_VEL: fresh[0] <= 1'b1;
               nac_pkg::ID_HEADING: fresh[1] <= 1'b1;
               nac_pkg::ID_EXT_TIME: fresh[2] <= 1'b1;
               nac_pkg::ID_DEPTH: fresh[3] <= 1'b1;
               default: fresh[4] <= 1'b1;
            endcase
         end
         if (state == NAC_IDLE && hdr_valid && hdr_write && hdr_len != 8'h00 &&
             hdr_id != nac_pkg::ID_CORR && !wr_ok(hdr_id, hdr_len)) begin
            discard <= 1'b1;
         end
      end
   end

   // ****************************************
   // APB slave, zero wait states
   // ****************************************
   assign pready = 1'b1;
   assign pslverr = psel && penable && paddr[11:7] == 5'h00 ?
                    (widx >= 5'(nac_pkg::NWORDS)) :
                    psel && penable && paddr != nac_pkg::ADDR_STATUS && paddr != nac_pkg::ADDR_CTRL;

   // Read data is loaded in the setup cycle so the access cycle sees a flop output.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr[11:7] == 5'h00 && widx < 5'(nac_pkg::NWORDS)) begin
            prdata <= wd[widx];
         end else if (paddr == nac_pkg::ADDR_STATUS) begin
            prdata[nac_pkg::ST_WIND_FIXED] <= wind_fixed;
            prdata[nac_pkg::ST_WIND_VALID] <= wind_valid;
            prdata[nac_pkg::ST_FRESH_LO +: 5] <= fresh;
            prdata[nac_pkg::ST_DISCARD] <= discard;
         end else if (paddr == nac_pkg::ADDR_CTRL) begin
            prdata[nac_pkg::CTRL_AIR] <= ctrl_air;
         end
      end
   end

   // ****************************************
   // Transmit path
   // ****************************************
   assign tx_word = wd[cur_base + 5'(cnt[4:2])];
   assign tx_byte = tx_word[8*cnt[1:0] +: 8];
   assign tx_id = cur_id;
   assign tx_len = cur_len;

   // The buffer keeps a stalled receiver from losing the byte already fetched.
   nac_buf2 #(
      .W(9)
   ) u_txbuf (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .in_valid(state == NAC_SEND),
      .in_ready(buf_in_ready),
      .in_data({pl_last, tx_byte}),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(buf_out)
   );
   assign tx_data = buf_out[7:0];
   assign tx_last = buf_out[8];

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_wind_commit;
      commit && cur_id == nac_pkg::ID_WIND;
   endsequence
   sequence s_fixed_held;
      wind_fixed [*2];
   endsequence

   property p_wind_fix;
      s_wind_commit |=> s_fixed_held;
   endproperty
   a_wind_fix: assert property (p_wind_fix) else $error("wind write did not fix wind");

   property p_bad_len;
      state == NAC_IDLE && hdr_valid && hdr_write && hdr_id == nac_pkg::ID_HEADING &&
      hdr_len == nac_pkg::LEN_WIND |=> state == NAC_DROP;
   endproperty
   a_bad_len: assert property (p_bad_len) else $error("bad length not dropped");

   property p_ro_write;
      state == NAC_IDLE && hdr_valid && hdr_write && hdr_id == nac_pkg::ID_RUN_TIME &&
      hdr_len != 8'h00 |=> state == NAC_DROP;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write accepted");

   property p_wo_read;
      state == NAC_IDLE && hdr_valid && !hdr_write && hdr_id == nac_pkg::ID_EXT_TIME
      |=> state == NAC_IDLE;
   endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only packet emitted");

   property p_short_copy;
      commit && cur_id == nac_pkg::ID_BODY_VEL && cur_len == nac_pkg::LEN_VEL_SHORT
      |=> wd[5'd4] == wd[5'd3] && wd[5'd5] == wd[5'd3];
   endproperty
   a_short_copy: assert property (p_short_copy) else $error("shared deviation not copied");

   property p_wind_valid;
      !ctrl_air && !pitot_s2 |-> !wind_valid;
   endproperty
   a_wind_valid: assert property (p_wind_valid) else $error("wind valid without air data");

   property p_run_len;
      state == NAC_IDLE && hdr_valid && !hdr_write && hdr_id == nac_pkg::ID_RUN_TIME
      |=> state == NAC_SEND && tx_len == nac_pkg::LEN_PAIR ##1 (state == NAC_SEND) [*7];
   endproperty
   a_run_len: assert property (p_run_len) else $error("running time length wrong");

   property p_corr_pass;
      state == NAC_CORR |-> corr_valid == pl_valid && pl_ready == corr_ready;
   endproperty
   a_corr_pass: assert property (p_corr_pass) else $error("corrections not passed");

   property p_odo_zero;
      state == NAC_SEND && cur_id == nac_pkg::ID_ODO && cnt > 8'h10 |-> tx_byte == 8'h00;
   endproperty
   a_odo_zero: assert property (p_odo_zero) else $error("odometer reserved not zero");
endmodule : nac_codec

// ### tb/nac_host.sv
// Host model: sends aiding packets, requests state packets, sinks emitted and correction bytes.
// Assumes the bench calls send and reads rx_q and corr_q by hierarchical name.
`timescale 1ns/1ps
module nac_host (
   input wire logic ref_clk,
   output logic hdr_valid,
   input wire logic hdr_ready,
   output logic [7:0] hdr_id,
   output logic [7:0] hdr_len,
   output logic hdr_write,
   output logic pl_valid,
   input wire logic pl_ready,
   output logic [7:0] pl_data,
   input wire logic corr_valid,
   output logic corr_ready,
   input wire logic [7:0] corr_data,
   input wire logic corr_last,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last
);
   logic [8:0] rx_q[$];
   logic [8:0] corr_q[$];
   logic [2:0] pace = 3'h0;
   initial begin
      hdr_valid = 1'b0;
      hdr_id = 8'h00;
      hdr_len = 8'h00;
      hdr_write = 1'b0;
      pl_valid = 1'b0;
      pl_data = 8'h00;
      tx_ready = 1'b0;
      corr_ready = 1'b0;
   end
   // Both sinks stall now and then, so the output buffer must hold its words.
   always @(posedge ref_clk) begin
      pace <= pace + 3'h1;
      tx_ready <= pace != 3'h2;
      corr_ready <= pace != 3'h5;
      if (tx_valid && tx_ready) rx_q.push_back({tx_last, tx_data});
      if (corr_valid && corr_ready) corr_q.push_back({corr_last, corr_data});
   end
   // The header length is the caller's; only a refusal scenario sets it wrong.
   task automatic send(input logic [7:0] id, input logic [7:0] len, input logic wr, input logic [7:0] first,
                       output bit ok);
      int n;
      ok = 1'b1;
      @(posedge ref_clk);
      hdr_id <= id;
      hdr_len <= len;
      hdr_write <= wr;
      hdr_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hdr_ready !== 1'b1 && n < 50);
      if (hdr_ready !== 1'b1) ok = 1'b0;
      hdr_valid <= 1'b0;
      hdr_id <= ~id;
      for (int k = 0; k < len && wr && ok; k++) begin
         pl_valid <= 1'b1;
         pl_data <= first + k[7:0];
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (pl_ready !== 1'b1 && n < 50);
         if (pl_ready !== 1'b1) ok = 1'b0;
      end
      pl_valid <= 1'b0;
      pl_data <= ~pl_data;
      @(negedge ref_clk);
   endtask : send
endmodule : nac_host

// ### tb/testbench.sv
// Self-checking bench for the packet codec: APB tasks and host packet exchanges.
// Assumes nac_host as the far side and a 40 MHz clock.
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic pitot_present = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdv;
   logic [31:0] exp_w[23];
   logic pready, pslverr, err, hdr_valid, hdr_ready, hdr_write, pl_valid, pl_ready;
   logic corr_valid, corr_ready, corr_last, tx_valid, tx_ready, tx_last, wind_valid, wind_fixed;
   logic [7:0] hdr_id, hdr_len, pl_data, corr_data, tx_data, tx_id, tx_len;
   int bad_count = 0;
   int checks_done = 0;
   bit ok;
   logic [7:0] wid[4] = '{8'h30, 8'h34, 8'h35, 8'h39};
   int wl[4] = '{8, 8, 8, 12};
   int wb[4] = '{6, 15, 17, 20};
   logic [7:0] rid[6] = '{8'h30, 8'h31, 8'h33, 8'h35, 8'h36, 8'h39};
   int rl[6] = '{8, 8, 20, 8, 4, 12};
   int rb[6] = '{6, 8, 10, 17, 19, 20};
   always #12.5 ref_clk = ~ref_clk;
   nac_codec uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_id(hdr_id), .hdr_len(hdr_len), .hdr_write(hdr_write),
      .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data), .corr_valid(corr_valid),
      .corr_ready(corr_ready), .corr_data(corr_data), .corr_last(corr_last), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_id(tx_id), .tx_len(tx_len),
      .pitot_present(pitot_present), .wind_valid(wind_valid), .wind_fixed(wind_fixed));
   nac_host host (.ref_clk(ref_clk), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_id(hdr_id),
      .hdr_len(hdr_len), .hdr_write(hdr_write), .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data),
      .corr_valid(corr_valid), .corr_ready(corr_ready), .corr_data(corr_data), .corr_last(corr_last),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic hang;
      bad_count++;
      $display("MISMATCH %0t wait ran out", $time);
      test_done();
   endtask : hang
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang();
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge ref_clk);
   endtask : apb
   task automatic wr(input int i, input logic [31:0] v, input bit upd);
      apb(1'b1, 12'(i * 4), v);
      if (upd) exp_w[i] = (i == 14) ? (v & nac_pkg::ODO_ACTIVE_MASK) : v;
   endtask : wr
   task automatic rng(input int b, input int n);
      for (int i = b; i < b + n; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0000_0000);
         chk(rdv, exp_w[i]);
      end
   endtask : rng
   task automatic wr_pkt(input logic [7:0] id, input int len, input int b, input logic [7:0] f, input bit upd);
      host.send(id, 8'(len), 1'b1, f, ok);
      if (!ok) hang();
      for (int k = 0; k < len && upd; k++) exp_w[b + k / 4][8 * (k % 4) +: 8] = f + k[7:0];
   endtask : wr_pkt
   task automatic rd_pkt(input logic [7:0] id, input int len, input int b);
      int n;
      host.rx_q.delete();
      host.send(id, 8'(len), 1'b0, 8'h00, ok);
      for (n = 0; host.rx_q.size() < len && n < 300; n++) @(posedge ref_clk);
      if (!ok || host.rx_q.size() < len) hang();
      if (len == 0) repeat (20) @(posedge ref_clk);
      chk(host.rx_q.size(), len);
      for (int k = 0; k < len; k++) chk(host.rx_q[k], {k == len - 1, exp_w[b + k / 4][8 * (k % 4) +: 8]});
      if (len > 0) chk({tx_id, tx_len}, {id, 8'(len)});
   endtask : rd_pkt
   initial begin
      repeat (20000) @(posedge ref_clk);
      hang();
   end
   initial begin
      for (int i = 0; i < 23; i++) exp_w[i] = 32'h0000_0000;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      rng(0, 23);
      wr_pkt(8'h2F, 16, 0, 8'h20, 1'b1);
      exp_w[4] = exp_w[3];
      exp_w[5] = exp_w[3];
      rng(0, 6);
      wr_pkt(8'h2F, 24, 0, 8'h40, 1'b1);
      rng(0, 6);
      rd_pkt(8'h2F, 24, 0);
      for (int i = 0; i < 4; i++) begin
         wr_pkt(wid[i], wl[i], wb[i], 8'h60 + 8'(i * 16), 1'b1);
         rng(wb[i], wl[i] / 4);
      end
      chk(wind_fixed, 32'h0000_0001);
      for (int i = 8; i < 14; i++) wr(i, 32'hA5A5_0000 + i, 1'b1);
      wr(14, 32'hFFFF_FFAB, 1'b1);
      wr(19, 32'h4128_0000, 1'b1);
      wr(20, 32'hDEAD_0000, 1'b0);
      wr(6, 32'hDEAD_0001, 1'b0);
      rng(6, 17);
      for (int i = 0; i < 6; i++) rd_pkt(rid[i], rl[i], rb[i]);
      rd_pkt(8'h34, 0, 0);
      rd_pkt(8'h37, 0, 0);
      apb(1'b1, nac_pkg::ADDR_STATUS, 32'h0000_3F00);
      wr_pkt(8'h30, 12, 6, 8'hAA, 1'b0);
      wr_pkt(8'h2F, 20, 0, 8'hAB, 1'b0);
      wr_pkt(8'h31, 8, 8, 8'hBB, 1'b0);
      rng(0, 10);
      apb(1'b0, nac_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rdv[13], 32'h0000_0001);
      wr_pkt(8'h37, 5, 0, 8'h50, 1'b0);
      chk(host.corr_q.size(), 5);
      for (int k = 0; k < 5; k++) chk(host.corr_q[k], {k == 4, 8'h50 + k[7:0]});
      apb(1'b1, nac_pkg::ADDR_CTRL, 32'h0000_0001);
      chk(wind_valid, 32'h0000_0001);
      apb(1'b1, nac_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(wind_valid, 32'h0000_0000);
      @(posedge ref_clk);
      pitot_present <= 1'b1;
      for (int n = 0; n < 8 && wind_valid !== 1'b1; n++) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(wind_valid, 32'h0000_0001);
      apb(1'b1, nac_pkg::ADDR_CTRL, 32'h0000_0002);
      chk(wind_fixed, 32'h0000_0000);
      wr(20, 32'h1234_5678, 1'b1);
      rng(20, 1);
      apb(1'b1, nac_pkg::ADDR_STATUS, 32'h0000_3F00);
      wr_pkt(8'h30, 0, 6, 8'h00, 1'b0);
      apb(1'b0, nac_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rdv, 32'h0000_0002);
      apb(1'b0, 12'h05C, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      chk(rdv, 32'h0000_0000);
      test_done();
   end
endmodule : testbench
